// [common/hph_pkg.sv]
// Package for the host port halfword access block: select codes,
// reset values, pin and system-side carriers, and the state encoding.
// Assumes one system clock; host pins arrive asynchronously.
package hph_pkg;

  ////////////////////////////////////////////////////////////////////
  // Register select codes
  localparam logic [1:0] SEL_CTRL     = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDR     = 2'h2;
  localparam logic [1:0] SEL_DATA     = 2'h3;

  ////////////////////////////////////////////////////////////////////
  // Widths, field positions and reset values
  localparam int          HALF_W        = 16;
  localparam int          HI_LSB        = 16;
  localparam logic        HW_FIRST      = 1'b0;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
  localparam logic [31:0] DOUT_RST      = 32'h0000_0000;
  localparam logic [3:0]  BE_NONE_N     = 4'hf;

  ////////////////////////////////////////////////////////////////////
  // Host pins after synchronisation
  typedef struct packed {
    logic        chip_select_n;
    logic        combined_strobe_n;
    logic        addr_strobe_n;
    logic        read_not_write;
    logic        halfword_ident;
    logic [1:0]  reg_select;
    logic [3:0]  byte_enable_n;
    logic [15:0] host_addr_lines;
    logic [31:0] host_din;
  } hph_pins_t;

  localparam int        PINS_W    = $bits(hph_pins_t);
  localparam hph_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
                                      2'h0, 4'hf, 16'h0, 32'h0};

  // FIFO and address path status from the system side
  typedef struct packed {
    logic        rd_empty;
    logic        rd_last;
    logic        rd_flush;
    logic        rd_done;
    logic        wr_full;
    logic        wr_last;
    logic        wr_empty;
    logic        wr_flush;
    logic        addr_busy;
    logic [31:0] rd_head;
  } hph_stat_t;

  // Requests toward the system side
  typedef struct packed {
    logic        wr_stb;
    logic        rd_pop;
    logic        rd_fetch;
    logic [1:0]  sel;
    logic [31:0] wdata;
    logic [3:0]  be_n;
    logic [31:0] addr;
  } hph_req_t;

  localparam hph_req_t REQ_IDLE = '{1'b0, 1'b0, 1'b0, 2'h0, 32'h0,
                                    4'hf, 32'h0};

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_BUSY
  } hph_fsm_t;

endpackage : hph_pkg

// [design/hph_core.sv]
// Host port access logic: strobe-edge control capture, register
// select decode, halfword pairing and ready stalls.
// Assumes the system side answers requests and reports FIFO state
// on the same clock.
`timescale 1ns/1ps

// Contract
// [R1] Mux mode: capture controls at strobe fall
// [R2] Address strobe fall captures controls instead
// [R3] Mux decode: ctrl, data inc, addr, data
// [R4] Byte enables ignored on reads
// [R5] Host samples read data at strobe rise
// [R6] Write data and enables taken at rise
// [R7] Two enables taken per halfword write
// [R8] Host: partial enables only plain data writes
// [R9] Start stall only while chip select asserted
// [R10] End stall held until chip select released
// [R11] No stall for ctrl, addr, nonempty reads
// [R12] Stall plain data reads, empty inc reads
// [R13] Stall after read that empties FIFO
// [R14] Stall addr write pending, full write FIFO
// [R15] Plain data write: stall busy FIFO, after
// [R16] Stall after filling write; ctrl never stalls
// [R17] Non-mux: no addr strobe, address at fall
// [R18] Non-mux decode: ctrl, data; others reserved
// [R19] Non-mux upper address from config inputs
// [R20] Non-mux write FIFO one word deep
// [R21] Non-mux data read stalls until data
// [R22] Host: non-mux partial enables only data
// [R23] Host: first halfword low ident, then high
module hph_core
  import hph_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire hph_pins_t  pins,
  input  wire logic       mux_mode,
  input  wire logic       use_addr_strobe,
  input  wire logic [7:0] upper_addr_msb_cfg,
  input  wire logic [7:0] upper_addr_umb_cfg,
  input  wire hph_stat_t  stat,
  output logic [31:0]     host_dout,
  output logic            host_dout_oe,
  output logic            host_ready_n,
  output logic [31:0]     host_ctrl_reg,
  output hph_req_t        req
);

  ////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    hph_fsm_t    fsm;
    logic        strb_q;
    logic        as_q;
    logic [1:0]  lat_sel;
    logic        lat_hw;
    logic        lat_rnw;
    logic [1:0]  sel;
    logic        hw;
    logic        rnw;
    logic        mux;
    logic [15:0] addr_lo;
    logic        got;
    logic        after;
    logic [15:0] wr_hi;
    logic [1:0]  be_hi;
    logic [31:0] rd_word;
    logic [31:0] ctrl;
    logic [31:0] addr;
    logic [31:0] dout;
    logic        doe;
    logic        rdy_n;
    hph_req_t    req;
  } hph_core_st_t;

  hph_core_st_t s;
  hph_core_st_t next_s;
  hph_pins_t    f;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  hph_sync #(
    .W       (PINS_W),
    .RST_VAL (PINS_IDLE)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (pins),
    .dout (f)
  );

  ////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Select codes 01 and 10 carry no register in non-mux mode
  function automatic logic is_reserved(input logic       mux,
                                       input logic [1:0] sel);
    is_reserved = !mux && (sel == SEL_DATA_INC || sel == SEL_ADDR);
  endfunction : is_reserved

  // First cycle of a word: every non-mux cycle, ident low in mux
  function automatic logic is_first(input logic mux, input logic hw);
    is_first = !mux || (hw == HW_FIRST);
  endfunction : is_first

  function automatic logic is_last(input logic mux, input logic hw);
    is_last = !mux || (hw != HW_FIRST);
  endfunction : is_last

  // Whether the access in hand must hold ready off before it starts
  function automatic logic start_stall(input hph_core_st_t c,
                                       input hph_stat_t    st);
    logic r;
    r = 1'b0;
    if (is_reserved(c.mux, c.sel)) begin
      r = 1'b0;
    end else if (c.rnw) begin
      if (is_first(c.mux, c.hw)) begin
        case (c.sel)
          SEL_DATA_INC: r = st.rd_empty || st.rd_flush; // see [R12]
          SEL_DATA:     r = !c.got;          // see [R12] see [R21]
          default:      r = 1'b0;                        // see [R11]
        endcase
      end
    end else if (is_last(c.mux, c.hw)) begin          // see [R9]
      case (c.sel)
        SEL_ADDR:     r = st.addr_busy;                  // see [R14]
        SEL_DATA_INC: r = st.wr_full || st.wr_flush;     // see [R14]
        SEL_DATA: begin
          if (c.mux) begin
            r = !st.wr_empty || st.wr_flush;             // see [R15]
          end else begin
            r = st.wr_full;                              // see [R20]
          end
        end
        default:      r = 1'b0;                          // see [R16]
      endcase
    end
    start_stall = r;
  endfunction : start_stall

  ////////////////////////////////////////////////////////////////////
  // Next state

  logic        cs;
  logic        fall;
  logic        rise;
  logic        as_fall;
  logic [31:0] word;
  logic [3:0]  be_n;
  logic        stall;

  always_comb begin
    next_s   = s;
    cs       = !f.chip_select_n;
    fall     = s.strb_q && !f.combined_strobe_n;
    rise     = !s.strb_q && f.combined_strobe_n;
    as_fall  = s.as_q && !f.addr_strobe_n;
    word     = 32'h0;
    be_n     = BE_NONE_N;
    stall    = 1'b0;

    next_s.strb_q       = f.combined_strobe_n;
    next_s.as_q         = f.addr_strobe_n;
    next_s.req.wr_stb   = 1'b0;
    next_s.req.rd_pop   = 1'b0;
    next_s.req.rd_fetch = 1'b0;

    // Releasing chip select ends any hold after an access
    if (!cs) begin
      next_s.after = 1'b0;                               // see [R10]
    end

    // Address strobe is honoured only in multiplexed mode
    if (mux_mode && use_addr_strobe && as_fall) begin   // see [R17]
      next_s.lat_sel = f.reg_select;                     // see [R2]
      next_s.lat_hw  = f.halfword_ident;
      next_s.lat_rnw = f.read_not_write;
    end

    if (stat.rd_done) begin
      next_s.rd_word = stat.rd_head;
      next_s.got     = 1'b1;
    end

    case (s.fsm)
      ST_IDLE: begin
        if (cs && fall) begin
          next_s.mux = mux_mode;
          next_s.got = 1'b0;
          if (mux_mode && use_addr_strobe) begin
            next_s.sel = s.lat_sel;                      // see [R2]
            next_s.hw  = s.lat_hw;
            next_s.rnw = s.lat_rnw;
          end else begin
            next_s.sel = f.reg_select;                   // see [R1]
            next_s.hw  = mux_mode ? f.halfword_ident : HW_FIRST;
            next_s.rnw = f.read_not_write;
          end
          if (!mux_mode) begin
            next_s.addr_lo = f.host_addr_lines;          // see [R17]
          end
          // A plain data read asks the system for a fresh word
          if (next_s.rnw && next_s.sel == SEL_DATA &&
              is_first(mux_mode, next_s.hw)) begin
            next_s.req.rd_fetch = 1'b1;
          end
          next_s.fsm = ST_WAIT;
        end
      end

      ST_WAIT: begin
        if (!cs) begin
          next_s.fsm = ST_IDLE;
        end else if (!start_stall(next_s, stat)) begin
          if (s.rnw) begin
            if (is_first(s.mux, s.hw)) begin
              case (s.sel)
                SEL_CTRL:     word = s.ctrl;
                SEL_ADDR:     word = s.addr;
                SEL_DATA_INC: word = stat.rd_head;
                default:      word = next_s.rd_word;
              endcase
              if (is_reserved(s.mux, s.sel)) begin       // see [R18]
                word = 32'h0;
              end
              next_s.rd_word = word;
              if (s.mux) begin
                next_s.dout = {16'h0, word[HI_LSB +: HALF_W]};
              end else begin
                next_s.dout = word;
              end
            end else begin
              next_s.dout = {16'h0, s.rd_word[HALF_W-1:0]};
            end
            next_s.doe = 1'b1;
          end
          next_s.fsm = ST_BUSY;
        end
      end

      ST_BUSY: begin
        if (!cs) begin
          next_s.doe = 1'b0;
          next_s.fsm = ST_IDLE;
        end else if (rise) begin
          // Data stays driven until the host has sampled it
          next_s.doe = 1'b0;                             // see [R5]
          next_s.fsm = ST_IDLE;
          if (s.rnw) begin
            // Enables play no part in a read               see [R4]
            if (s.sel == SEL_DATA_INC && is_last(s.mux, s.hw) &&
                !is_reserved(s.mux, s.sel)) begin
              next_s.req.rd_pop = 1'b1;
              next_s.after      = stat.rd_last;          // see [R13]
            end
          end else if (!is_last(s.mux, s.hw)) begin
            next_s.wr_hi = f.host_din[HALF_W-1:0];       // see [R23]
            next_s.be_hi = f.byte_enable_n[1:0];         // see [R7]
          end else if (!is_reserved(s.mux, s.sel)) begin
            if (s.mux) begin
              word = {s.wr_hi, f.host_din[HALF_W-1:0]};
              be_n = {s.be_hi, f.byte_enable_n[1:0]};    // see [R7]
            end else begin
              word = f.host_din;                         // see [R6]
              be_n = f.byte_enable_n;                    // see [R6]
            end
            // Partial enables are the host's concern   see [R8] [R22]
            next_s.req.wr_stb = 1'b1;
            next_s.req.sel    = s.sel;
            next_s.req.wdata  = word;
            next_s.req.be_n   = be_n;
            if (s.mux) begin
              next_s.req.addr = s.addr;
            end else begin
              next_s.req.addr = {upper_addr_msb_cfg,      // see [R19]
                                 upper_addr_umb_cfg,
                                 s.addr_lo};
            end
            case (s.sel)
              SEL_CTRL: begin
                next_s.ctrl = word;                      // see [R16]
              end
              SEL_ADDR: begin
                next_s.addr = word;                      // see [R3]
              end
              SEL_DATA_INC: begin
                next_s.after = stat.wr_last;             // see [R16]
              end
              SEL_DATA: begin
                next_s.after = 1'b1;              // see [R15] see [R20]
              end
              default: begin
                next_s.after = 1'b0;
              end
            endcase
          end
        end
      end

      default: begin
        next_s.fsm = ST_IDLE;
      end
    endcase

    // Ready is held off only while the host has the chip selected
    if (next_s.fsm == ST_WAIT) begin
      stall = start_stall(next_s, stat);
    end
    next_s.rdy_n = cs && (stall || next_s.after);  // see [R9] see [R10]
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s         <= '0;
      s.fsm     <= ST_IDLE;
      s.strb_q  <= 1'b1;
      s.as_q    <= 1'b1;
      s.lat_rnw <= 1'b1;
      s.rnw     <= 1'b1;
      s.be_hi   <= 2'h3;
      s.ctrl    <= CTRL_RST;
      s.addr    <= ADDR_RST;
      s.dout    <= DOUT_RST;
      s.req     <= REQ_IDLE;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign host_dout     = s.dout;
  assign host_dout_oe  = s.doe;
  assign host_ready_n  = s.rdy_n;
  assign host_ctrl_reg = s.ctrl;
  assign req           = s.req;

endmodule : hph_core

// [design/hph_sync.sv]
// Three-stage synchroniser for a bundle of asynchronous host pins.
// Assumes the bundle's reset value is given as a parameter.
`timescale 1ns/1ps
module hph_sync #(
  parameter int           W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } hph_sync_st_t;

  hph_sync_st_t s;
  hph_sync_st_t next_s;

  // A bit changes only once stages two and three agree
  always_comb begin
    next_s    = s;
    next_s.s1 = din;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.q[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.q;

endmodule : hph_sync

// [verif/hph_core_chk.sv]
// Assertion checker for the host port access core.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
module hph_core_chk
  import hph_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire hph_pins_t   pins,
  input wire logic        mux_mode,
  input wire logic        use_addr_strobe,
  input wire logic [7:0]  upper_addr_msb_cfg,
  input wire logic [7:0]  upper_addr_umb_cfg,
  input wire hph_stat_t   stat,
  input wire logic [31:0] host_dout,
  input wire logic        host_dout_oe,
  input wire logic        host_ready_n,
  input wire logic [31:0] host_ctrl_reg,
  input wire hph_req_t    req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////
  wr_pulse_a: assert property (
    req.wr_stb |=> (!req.wr_stb)[*3]) else $error("write strobe repeated");
  fetch_once_a: assert property (
    req.rd_fetch |=> (!req.rd_fetch)[*3]) else $error("fetch repeated");
  fetch_stall_a: assert property (
    req.rd_fetch |-> host_ready_n) else $error("fetch without stall");
  read_done_a: assert property (
    !mux_mode && stat.rd_done && host_ready_n |=> host_dout_oe &&
    !host_ready_n && host_dout == $past(stat.rd_head))
    else $error("read data not presented");
  upper_addr_a: assert property (
    !mux_mode && req.wr_stb |-> req.addr[31:16] ==
    {upper_addr_msb_cfg, upper_addr_umb_cfg}) else $error("upper address");
  half_zero_a: assert property (
    mux_mode && host_dout_oe |-> host_dout[31:16] == 16'h0)
    else $error("upper half not zero");
  ready_release_a: assert property (
    $rose(pins.chip_select_n) |-> ##[1:6] !host_ready_n)
    else $error("ready held after deselect");
  oe_release_a: assert property (
    $rose(pins.chip_select_n) |-> ##6 !host_dout_oe)
    else $error("data still driven");
  stall_cs_a: assert property (
    $rose(host_ready_n) |-> !pins.chip_select_n)
    else $error("stall while deselected");

  cover property (stat.rd_done);
  cover property (req.wr_stb && !mux_mode);
  cover property ($rose(host_ready_n));
endmodule : hph_core_chk

bind hph_core hph_core_chk u_chk (.clk(clk), .rst(rst), .pins(pins),
  .mux_mode(mux_mode), .use_addr_strobe(use_addr_strobe),
  .upper_addr_msb_cfg(upper_addr_msb_cfg),
  .upper_addr_umb_cfg(upper_addr_umb_cfg), .stat(stat),
  .host_dout(host_dout), .host_dout_oe(host_dout_oe),
  .host_ready_n(host_ready_n), .host_ctrl_reg(host_ctrl_reg), .req(req));

// [verif/hph_core_tb.sv]
// Self-checking bench: host model on the pins, bench as system side.
// Assumes the core reads FIFO state as same-clock levels.
`timescale 1ns/1ps
module hph_core_tb
  import hph_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mux_mode = 1'b1;
  logic        use_as = 1'b0;
  logic [7:0]  msb_cfg = 8'h3c;
  logic [7:0]  umb_cfg = 8'h5a;
  hph_stat_t   st;
  hph_pins_t   pins;
  hph_req_t    req;
  logic [31:0] dout, ctrl, rd;
  logic        oe, ready_n, s0, s1;
  logic [2:0]  fd = 3'h0;
  int          mismatches = 0;
  int          n_checks = 0;
  int          n_wr = 0;
  int          n_pop = 0;
  int          cycles = 0;

  always #25 clk = ~clk;
  hph_core dut (.clk(clk), .rst(rst), .pins(pins), .mux_mode(mux_mode),
    .use_addr_strobe(use_as), .upper_addr_msb_cfg(msb_cfg),
    .upper_addr_umb_cfg(umb_cfg), .stat(st), .host_dout(dout),
    .host_dout_oe(oe), .host_ready_n(ready_n), .host_ctrl_reg(ctrl),
    .req(req));
  hph_host_model host (.clk(clk), .host_ready_n(ready_n),
    .host_dout(dout), .pins(pins));

  // System side answers a fetch four cycles later
  always @(posedge clk) begin
    fd <= {fd[1:0], req.rd_fetch === 1'b1};
    st.rd_done <= fd[2];
    if (req.wr_stb === 1'b1) n_wr++;
    if (req.rd_pop === 1'b1) n_pop++;
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  function automatic logic [31:0] stl();
    return {30'h0, s0, s1};
  endfunction : stl

  task automatic acc(input logic [1:0] sel, input logic rnw, hw,
    input logic [31:0] d, input logic [3:0] be);
    host.xfer(use_as, sel, rnw, hw, d, be, rd, s0, s1);
  endtask : acc

  // Clears a stall condition 30 cycles from now
  task automatic free_later(input int k);
    fork
      begin
        repeat (30) @(posedge clk);
        case (k)
          0: st.wr_empty <= 1'b1;
          1: st.wr_full <= 1'b0;
          3: st.rd_empty <= 1'b0;
          4: st.wr_flush <= 1'b0;
          default: st.addr_busy <= 1'b0;
        endcase
      end
    join_none
  endtask : free_later

  ////////////////////////////////////////////////////////////////////
  task automatic t_ctrl;
    acc(SEL_CTRL, 1'b0, 1'b0, 32'h0000_1234, 4'h0);
    acc(SEL_CTRL, 1'b0, 1'b1, 32'h0000_5678, 4'h0);
    chk(ctrl, 32'h1234_5678);
    chk(stl(), 32'h0);
    acc(SEL_CTRL, 1'b1, 1'b0, 32'h0, 4'h5);
    chk(rd, 32'h0000_1234);
    acc(SEL_CTRL, 1'b1, 1'b1, 32'h0, 4'ha);
    chk(rd, 32'h0000_5678);
    chk(stl(), 32'h0);
    // Let the new strobe mode settle before the model reads it
    use_as <= 1'b1;
    @(posedge clk);
    acc(SEL_CTRL, 1'b0, 1'b0, 32'h0000_aaaa, 4'h0);
    acc(SEL_CTRL, 1'b0, 1'b1, 32'h0000_5555, 4'h0);
    chk(ctrl, 32'haaaa_5555);
    use_as <= 1'b0;
    @(posedge clk);
  endtask : t_ctrl

  task automatic t_wr;
    int w;
    w = n_wr;
    acc(SEL_DATA, 1'b0, 1'b0, 32'h0000_beef, 4'he);
    chk(stl(), 32'h0);
    acc(SEL_DATA, 1'b0, 1'b1, 32'h0000_f00d, 4'hd);
    chk(stl(), 32'h1);
    chk({31'h0, ready_n}, 32'h0);
    chk(req.wdata, 32'hbeef_f00d);
    chk({28'h0, req.be_n}, 32'h9);
    chk({30'h0, req.sel}, {30'h0, SEL_DATA});
    chk(32'(n_wr - w), 32'h1);
    st.wr_empty <= 1'b0;
    acc(SEL_DATA, 1'b0, 1'b0, 32'h0000_1111, 4'h0);
    free_later(0);
    acc(SEL_DATA, 1'b0, 1'b1, 32'h0000_2222, 4'h0);
    chk(stl(), 32'h3);
    st.wr_last <= 1'b1;
    acc(SEL_DATA_INC, 1'b0, 1'b0, 32'h0000_0001, 4'h0);
    acc(SEL_DATA_INC, 1'b0, 1'b1, 32'h0000_0002, 4'h0);
    chk(stl(), 32'h1);
    st.wr_last <= 1'b0;
    st.wr_full <= 1'b1;
    acc(SEL_DATA_INC, 1'b0, 1'b0, 32'h0000_0003, 4'h0);
    free_later(1);
    acc(SEL_DATA_INC, 1'b0, 1'b1, 32'h0000_0004, 4'h0);
    chk(stl(), 32'h2);
    st.addr_busy <= 1'b1;
    acc(SEL_ADDR, 1'b0, 1'b0, 32'h0000_8000, 4'h0);
    free_later(2);
    acc(SEL_ADDR, 1'b0, 1'b1, 32'h0, 4'h0);
    chk(stl(), 32'h2);
    acc(SEL_ADDR, 1'b1, 1'b0, 32'h0, 4'h0);
    chk(rd, 32'h0000_8000);
    chk({31'h0, s0}, 32'h0);
    acc(SEL_ADDR, 1'b1, 1'b1, 32'h0, 4'h0);
    st.wr_flush <= 1'b1;
    acc(SEL_DATA_INC, 1'b0, 1'b0, 32'h0000_0005, 4'h0);
    free_later(4);
    acc(SEL_DATA_INC, 1'b0, 1'b1, 32'h0000_0006, 4'h0);
    chk(stl(), 32'h2);
  endtask : t_wr

  task automatic t_rd;
    int p;
    st.rd_head <= 32'hcafe_f00d;
    acc(SEL_DATA, 1'b1, 1'b0, 32'h0, 4'h0);
    chk(rd, 32'h0000_cafe);
    chk({31'h0, s0}, 32'h1);
    acc(SEL_DATA, 1'b1, 1'b1, 32'h0, 4'h0);
    chk(rd, 32'h0000_f00d);
    st.rd_empty <= 1'b0;
    st.rd_head <= 32'h1357_2468;
    acc(SEL_DATA_INC, 1'b1, 1'b0, 32'h0, 4'h0);
    chk(rd, 32'h0000_1357);
    chk(stl(), 32'h0);
    p = n_pop;
    st.rd_last <= 1'b1;
    acc(SEL_DATA_INC, 1'b1, 1'b1, 32'h0, 4'h0);
    chk(stl(), 32'h1);
    chk(32'(n_pop - p), 32'h1);
    st.rd_empty <= 1'b1;
    free_later(3);
    acc(SEL_DATA_INC, 1'b1, 1'b0, 32'h0, 4'h0);
    chk({31'h0, s0}, 32'h1);
    chk(rd, 32'h0000_1357);
    acc(SEL_DATA_INC, 1'b1, 1'b1, 32'h0, 4'h0);
    chk(stl(), 32'h1);
  endtask : t_rd

  task automatic t_nm;
    int w;
    mux_mode <= 1'b0;
    acc(SEL_DATA, 1'b0, 1'b0, 32'h1234_abcd, 4'h3);
    chk(req.addr, 32'h3c5a_1234);
    chk(req.wdata, 32'h1234_abcd);
    chk({28'h0, req.be_n}, 32'h3);
    chk(stl(), 32'h1);
    st.wr_full <= 1'b1;
    free_later(1);
    acc(SEL_DATA, 1'b0, 1'b0, 32'h5678_0000, 4'h0);
    chk(stl(), 32'h3);
    w = n_wr;
    acc(SEL_DATA_INC, 1'b0, 1'b0, 32'h0, 4'h0);
    chk(32'(n_wr - w), 32'h0);
    acc(SEL_ADDR, 1'b1, 1'b0, 32'h0, 4'h0);
    chk(rd, 32'h0);
    chk(stl(), 32'h0);
    acc(SEL_DATA, 1'b1, 1'b0, 32'h0, 4'h0);
    chk(rd, 32'h1357_2468);
    chk({31'h0, s0}, 32'h1);
    mux_mode <= 1'b1;
  endtask : t_nm

  initial begin
    st = '0;
    st.rd_empty = 1'b1;
    st.wr_empty = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_ctrl();
    t_wr();
    t_rd();
    t_nm();
    end_of_test();
  end
endmodule : hph_core_tb

// [verif/hph_host_model.sv]
// Host microprocessor model driving the asynchronous host pins.
// Assumes the core answers on host_ready_n and host_dout.
`timescale 1ns/1ps
module hph_host_model
  import hph_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        host_ready_n,
  input  wire logic [31:0] host_dout,
  output hph_pins_t        pins
);
  initial pins = PINS_IDLE;

  // One cycle; st0 = stalled before strobe rise, st1 = after it
  task automatic xfer(input logic as_en, input logic [1:0] sel,
    input logic rnw, hw, input logic [31:0] d, input logic [3:0] be,
    output logic [31:0] rd, output logic st0, st1);
    int n;
    st0 = 1'b0;
    st1 = 1'b0;
    @(posedge clk);
    pins.chip_select_n   <= 1'b0;
    pins.addr_strobe_n   <= !as_en;
    pins.reg_select      <= sel;
    pins.read_not_write  <= rnw;
    pins.halfword_ident  <= hw;
    pins.byte_enable_n   <= be;
    pins.host_addr_lines <= d[31:16];
    pins.host_din        <= rnw ? ~pins.host_din : d;
    repeat (6) @(posedge clk);
    // Controls go stale once the address strobe has taken them
    if (as_en) begin
      pins.reg_select     <= ~sel;
      pins.read_not_write <= ~rnw;
      pins.halfword_ident <= ~hw;
    end
    @(posedge clk);
    pins.combined_strobe_n <= 1'b0;
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      #1;
      if (host_ready_n !== 1'b0) st0 = 1'b1;
      else if (n >= 7) break;
    end
    rd = host_dout;
    @(posedge clk);
    pins.combined_strobe_n <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge clk);
      #1;
      if (host_ready_n !== 1'b0) st1 = 1'b1;
    end
    @(posedge clk);
    pins.chip_select_n <= 1'b1;
    pins.addr_strobe_n <= 1'b1;
    pins.host_din      <= ~pins.host_din;
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : hph_host_model
